// *** clock_output_pair_control.sv ***
// register bank configuring clock outputs eight to eleven as two pairs
// assumes a byte register port synchronous to ref_clk and a remap
// level from the synthesizer two mailbox, also synchronous
//
// How it works
// - bit 7: pair ten/eleven CMOS or differential
// - bit 5: pair eight/nine CMOS or differential
// - remap picks eight/nine divider source
// - bit 3 enables eleven, CMOS only
// - bit 2 enables ten, both when differential
// - bit 1 enables nine, CMOS only
// - bit 0 enables eight, both when differential
// - remap 0: route bit picks synth three B/A
// - remap 1: route bit picks synth two D/C
`timescale 1ns/10ps
`include "clock_output_pair_params.svh"

module clock_output_pair_control
  import clock_output_pair_pkg::*;
(
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_wdata,
  output      logic [7:0]  reg_rdata,
  // mailbox remap level
  input  wire logic        synth_two_mailbox_remap,
  // output driver controls
  output      pair_drive_t pair_eight_drive,
  output      pair_drive_t pair_ten_drive
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] output_pair_type_enable_c;   // type and enable bits
  logic [7:0] output_pair_source_select_c; // routing bit
  pair_drive_t next_pair_eight;            // decoded pair 8/9 state
  pair_drive_t next_pair_ten;              // decoded pair 10/11 state

  // register writes; reserved bits masked so they always hold zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      output_pair_type_enable_c   <= `TYPE_ENABLE_RESET;
      output_pair_source_select_c <= `SOURCE_SELECT_RESET;
    end
    else if (clk_en && reg_write)
    begin
      if (reg_addr == `TYPE_ENABLE_ADDR)
        output_pair_type_enable_c <= reg_wdata & `TYPE_ENABLE_MASK;
      else if (reg_addr == `SOURCE_SELECT_ADDR)
        output_pair_source_select_c <= reg_wdata & `SOURCE_SELECT_MASK;
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= `READ_IDLE_DATA;
    else if (clk_en && reg_read)
    begin
      if (reg_addr == `TYPE_ENABLE_ADDR)
        reg_rdata <= output_pair_type_enable_c;
      else if (reg_addr == `SOURCE_SELECT_ADDR)
        reg_rdata <= output_pair_source_select_c;
      else
        reg_rdata <= `READ_IDLE_DATA;
    end
  end

  // ----------------------------------------------------------------
  // output decode
  // ----------------------------------------------------------------
  always_comb
  begin
    next_pair_eight.differential =
      output_pair_type_enable_c[`PAIR_EIGHT_TYPE_BIT];
    next_pair_ten.differential =
      output_pair_type_enable_c[`PAIR_TEN_TYPE_BIT];
    // eight, or whole pair when differential
    next_pair_eight.enable[0] =
      output_pair_type_enable_c[`OUT_EIGHT_EN_BIT];
    // nine ignores own bit when differential
    next_pair_eight.enable[1] = next_pair_eight.differential ?
      output_pair_type_enable_c[`OUT_EIGHT_EN_BIT] :
      output_pair_type_enable_c[`OUT_NINE_EN_BIT];
    // ten, or whole pair when differential
    next_pair_ten.enable[0] =
      output_pair_type_enable_c[`OUT_TEN_EN_BIT];
    // eleven ignores own bit when differential
    next_pair_ten.enable[1] = next_pair_ten.differential ?
      output_pair_type_enable_c[`OUT_TEN_EN_BIT] :
      output_pair_type_enable_c[`OUT_ELEVEN_EN_BIT];
    // remap moves pair eight to synth two
    next_pair_eight.source = synth_two_mailbox_remap ?
      synth_two_div_c : synth_three_div_a;
    // synth three B or A when not remapped
    // synth two D or C when remapped
    if (synth_two_mailbox_remap)
      next_pair_ten.source =
        output_pair_source_select_c[`PAIR_TEN_SOURCE_BIT] ?
        synth_two_div_c : synth_two_div_d;
    else
      next_pair_ten.source =
        output_pair_source_select_c[`PAIR_TEN_SOURCE_BIT] ?
        synth_three_div_a : synth_three_div_b;
  end

  // output flops; one cycle behind the registers and remap level
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      // reset drives match the decode of the register reset values
      // with remap low; a high remap shows one edge after release
      pair_eight_drive <= '{`DRIVE_RESET_TYPE, `DRIVE_RESET_ENABLE,
                            synth_three_div_a};
      pair_ten_drive   <= '{`DRIVE_RESET_TYPE, `DRIVE_RESET_ENABLE,
                            synth_three_div_b};
    end
    else if (clk_en)
    begin
      pair_eight_drive <= next_pair_eight;
      pair_ten_drive   <= next_pair_ten;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // each check except reserved_zero_a looks one edge after an enabled edge, as the drives are
  // flopped copies of the decode; the edge that leaves reset is skipped
  // in the source checks other than ten_route_a, since the drive flops then still
  // hold fixed reset sources

  ten_type_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en |=> pair_ten_drive.differential ==
      $past(output_pair_type_enable_c[`PAIR_TEN_TYPE_BIT]))
    else $error("pair ten type mismatch");

  eight_type_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en |=> pair_eight_drive.differential ==
      $past(output_pair_type_enable_c[`PAIR_EIGHT_TYPE_BIT]))
    else $error("pair eight type mismatch");

  eight_source_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !reset && synth_two_mailbox_remap |=>
      pair_eight_drive.source == synth_two_div_c)
    else $error("pair eight remap source wrong");

  eight_base_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !reset && !synth_two_mailbox_remap |=>
      pair_eight_drive.source == synth_three_div_a)
    else $error("pair eight base source wrong");

  eleven_enable_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !output_pair_type_enable_c[`PAIR_TEN_TYPE_BIT] |=>
      pair_ten_drive.enable[1] ==
        $past(output_pair_type_enable_c[`OUT_ELEVEN_EN_BIT]))
    else $error("eleven enable wrong in cmos");

  ten_joint_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && output_pair_type_enable_c[`PAIR_TEN_TYPE_BIT] |=>
      pair_ten_drive.enable[1] == pair_ten_drive.enable[0])
    else $error("pair ten joint enable broken");

  ten_enable_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en |=> pair_ten_drive.enable[0] ==
      $past(output_pair_type_enable_c[`OUT_TEN_EN_BIT]))
    else $error("ten enable wrong");

  nine_enable_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !output_pair_type_enable_c[`PAIR_EIGHT_TYPE_BIT] |=>
      pair_eight_drive.enable[1] ==
        $past(output_pair_type_enable_c[`OUT_NINE_EN_BIT]))
    else $error("nine enable wrong in cmos");

  eight_joint_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && output_pair_type_enable_c[`PAIR_EIGHT_TYPE_BIT] |=>
      pair_eight_drive.enable == {2{$past(
        output_pair_type_enable_c[`OUT_EIGHT_EN_BIT])}})
    else $error("pair eight joint enable broken");

  eight_enable_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en |=> pair_eight_drive.enable[0] ==
      $past(output_pair_type_enable_c[`OUT_EIGHT_EN_BIT]))
    else $error("eight enable wrong");

  ten_route_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !synth_two_mailbox_remap &&
      !output_pair_source_select_c[`PAIR_TEN_SOURCE_BIT] |=>
      pair_ten_drive.source == synth_three_div_b)
    else $error("pair ten synth three route wrong");

  ten_route_high_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !reset && !synth_two_mailbox_remap &&
      output_pair_source_select_c[`PAIR_TEN_SOURCE_BIT] |=>
      pair_ten_drive.source == synth_three_div_a)
    else $error("pair ten synth three high route wrong");

  ten_remap_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !reset && synth_two_mailbox_remap &&
      output_pair_source_select_c[`PAIR_TEN_SOURCE_BIT] |=>
      pair_ten_drive.source == synth_two_div_c)
    else $error("pair ten synth two route wrong");

  ten_remap_low_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && !reset && synth_two_mailbox_remap &&
      !output_pair_source_select_c[`PAIR_TEN_SOURCE_BIT] |=>
      pair_ten_drive.source == synth_two_div_d)
    else $error("pair ten synth two low route wrong");

  reserved_zero_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    (output_pair_source_select_c & ~`SOURCE_SELECT_MASK) == 8'h00 &&
    (output_pair_type_enable_c & ~`TYPE_ENABLE_MASK) == 8'h00)
    else $error("reserved bit set");

  unmapped_read_a: assert property (@(posedge ref_clk)
    disable iff (reset)
    clk_en && reg_read && reg_addr != `TYPE_ENABLE_ADDR &&
      reg_addr != `SOURCE_SELECT_ADDR |=> reg_rdata == `READ_IDLE_DATA)
    else $error("unmapped read not zero");

endmodule

// *** clock_output_pair_params.svh ***
// constants for the clock output pair control register bank
// assumes the device register port presents byte-wide accesses
`ifndef CLOCK_OUTPUT_PAIR_PARAMS_SVH
`define CLOCK_OUTPUT_PAIR_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define TYPE_ENABLE_ADDR   12'h254
`define SOURCE_SELECT_ADDR 12'h255

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define TYPE_ENABLE_RESET   8'hA0
`define SOURCE_SELECT_RESET 8'h00
`define TYPE_ENABLE_MASK    8'hAF
`define SOURCE_SELECT_MASK  8'h04

// ----------------------------------------------------------------
// idle read data and drive flop reset values
// ----------------------------------------------------------------
`define READ_IDLE_DATA      8'h00
`define DRIVE_RESET_TYPE    1'b1
`define DRIVE_RESET_ENABLE  2'b00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAIR_TEN_TYPE_BIT    7
`define PAIR_EIGHT_TYPE_BIT  5
`define OUT_ELEVEN_EN_BIT    3
`define OUT_TEN_EN_BIT       2
`define OUT_NINE_EN_BIT      1
`define OUT_EIGHT_EN_BIT     0
`define PAIR_TEN_SOURCE_BIT  2

`endif

// *** clock_output_pair_pkg.sv ***
// types for the clock output pair control register bank
// assumes the params header is included by the design module
package clock_output_pair_pkg;

  // ----------------------------------------------------------------
  // divider identifiers
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    synth_three_div_a = 3'h0,
    synth_three_div_b = 3'h1,
    synth_two_div_c   = 3'h2,
    synth_two_div_d   = 3'h3
  } divider_sel_t;

  // per-pair state handed to the output drivers
  typedef struct packed
  {
    logic         differential;
    logic [1:0]   enable;
    divider_sel_t source;
  } pair_drive_t;

endpackage

// *** clock_load_model.sv ***
// loads on clock outputs eight to eleven
// assumes registered drive structs from the bank
`timescale 1ns/10ps
module clock_load_model
  import clock_output_pair_pkg::*;
(
  // drives from the bank
  input  wire pair_drive_t eight,
  input  wire pair_drive_t ten,
  // outputs eleven down to eight carrying a clock
  output logic [3:0]       load_on
);
  // a load sees a clock only while its output is on
  assign load_on = {ten.enable, eight.enable};
endmodule

// *** tb_top.sv ***
// self-checking bench for the clock output pair bank
// assumes registered read data and a two-edge drive update
`timescale 1ns/10ps
`include "clock_output_pair_params.svh"
module tb_top
  import clock_output_pair_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        remap = 1'b0;
  pair_drive_t pair_eight_drive;
  pair_drive_t pair_ten_drive;
  logic [3:0]  load_on;
  logic        rd_seen = 1'b0;  // read taken at last edge
  logic        drv_chk = 1'b0;  // drive snapshot due
  logic [7:0]  te = 8'hA0;      // model of type/enable register
  logic [7:0]  ss = 8'h00;      // model of source register
  logic        rm = 1'b0;       // model of remap level
  logic [11:0] de;              // drive note taken off the queue
  logic [7:0]  rq[$];
  logic [11:0] dq[$];
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  clock_output_pair_control clock_output_pair_control_i
  (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .synth_two_mailbox_remap(remap),
   .pair_eight_drive(pair_eight_drive), .pair_ten_drive(pair_ten_drive));
  clock_load_model clock_load_model_i
  (.eight(pair_eight_drive), .ten(pair_ten_drive), .load_on(load_on));

  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  // watchdog well above the run length
  always @(posedge ref_clk)
  begin
    rd_seen <= reg_read & clk_en;
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      miscompares++;
      end_sim();
    end
  end

  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch reg_rdata exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_drv(input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch drives exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_load(input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch load_on exp %h got %h", e, g);
    end
  endtask

  // results are settled by the falling edge
  always @(negedge ref_clk)
  begin
    if (rd_seen)
      cmp_rd(rq.pop_front(), reg_rdata); // read back
    if (drv_chk)
    begin
      de = dq.pop_front();
      cmp_drv(de, {pair_eight_drive, pair_ten_drive});
      cmp_load({de[4:3], de[10:9]}, load_on);
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    if (clk_en && a == `TYPE_ENABLE_ADDR) te = d & `TYPE_ENABLE_MASK;
    if (clk_en && a == `SOURCE_SELECT_ADDR) ss = d & `SOURCE_SELECT_MASK;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask

  // differential: both enables follow the even bit
  task automatic chk();
    pair_drive_t e8;
    pair_drive_t e10;
    repeat (3) @(posedge ref_clk);
    e8 = {te[5], te[5] ? {2{te[0]}} : te[1:0],
          rm ? synth_two_div_c : synth_three_div_a};
    e10 = {te[7], te[7] ? {2{te[2]}} : te[3:2],
           rm ? (ss[2] ? synth_two_div_c : synth_two_div_d)
                 : (ss[2] ? synth_three_div_a : synth_three_div_b)};
    dq.push_back({e8, e10});
    drv_chk <= 1'b1;
    @(posedge ref_clk);
    drv_chk <= 1'b0;
  endtask

  initial
  begin
    void'($urandom(32'h78456fee));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    chk();
    rd(`TYPE_ENABLE_ADDR, 8'hA0);
    rd(`SOURCE_SELECT_ADDR, 8'h00);
    rd(12'h256, 8'h00);
    $display("test reset done");
    // random writes, unmapped places among them
    for (int i = 0; i < 64; i++)
    begin
      wr(12'h253 + 12'($urandom_range(3)), 8'($urandom));
      wr(12'h254 + 12'($urandom_range(1)), 8'($urandom));
      rm = 1'($urandom);
      remap <= rm;
      chk();
      rd(`TYPE_ENABLE_ADDR, te);
      rd(`SOURCE_SELECT_ADDR, ss);
    end
    $display("test random done");
    // a write with the enable low is lost and the drives hold
    clk_en <= 1'b0;
    remap <= ~rm;
    wr(`TYPE_ENABLE_ADDR, ~te);
    chk();
    clk_en <= 1'b1;
    rm = ~rm;
    rd(`TYPE_ENABLE_ADDR, te);
    chk();
    $display("test freeze done");
    // reset in mid-run brings back the reset values
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    te = `TYPE_ENABLE_RESET;
    ss = `SOURCE_SELECT_RESET;
    chk();
    rd(`TYPE_ENABLE_ADDR, te);
    rd(`SOURCE_SELECT_ADDR, ss);
    $display("test reset again done");
    end_sim();
  end

  task automatic end_sim();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
endmodule
